/* src/tsr_regs.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  triggered sweep recorder. Assumes it is included by bare name.
*/
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

`define TSR_OFF_CTRL 8'h00
`define TSR_OFF_PRE 8'h04
`define TSR_OFF_POST 8'h08
`define TSR_OFF_ALLOW 8'h0C
`define TSR_OFF_STATUS 8'h10
`define TSR_OFF_SWEEPS 8'h14
`define TSR_OFF_MISSES 8'h18
`define TSR_OFF_GAPS 8'h1C
`define TSR_OFF_BETWEEN 8'h20

`define TSR_CTRL_RUN 0
`define TSR_CTRL_MODE_LSB 1
`define TSR_CTRL_POL_LSB 3
`define TSR_CTRL_TSEL_LSB 5
`define TSR_CTRL_SSEL_LSB 8

`define TSR_RST_CTRL 32'h0000_03E0
`define TSR_RST_PRE 32'h0000_0010
`define TSR_RST_POST 32'h0000_0010

`define TSR_MIN_SWEEP 10
`define TSR_BTW_ALLOW_US 2500

`endif

/* src/tsr_pkg.sv */
/*
  Types of the triggered sweep recorder: modes, policies, states and the
  words carried on the register port and the output stream.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tsr_pkg;

  typedef enum logic [1:0] {
    TSR_MODE_STREAM,
    TSR_MODE_TRIG,
    TSR_MODE_BUF,
    TSR_MODE_BUF_LOW
  } tsr_mode_t;

  typedef enum logic [1:0] {
    TSR_POL_FIRST,
    TSR_POL_EVERY,
    TSR_POL_STOP,
    TSR_POL_RSVD
  } tsr_policy_t;

  typedef enum logic [1:0] {
    TSR_KIND_SAMPLE,
    TSR_KIND_TRIG,
    TSR_KIND_MISS,
    TSR_KIND_GAP
  } tsr_kind_t;

  typedef enum logic [2:0] {
    TSR_ST_IDLE,
    TSR_ST_STREAM,
    TSR_ST_PRE,
    TSR_ST_BTW,
    TSR_ST_POST,
    TSR_ST_DONE
  } tsr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tsr_bus_t;

  typedef struct packed {
    tsr_kind_t kind;
    logic [2:0] src;
    logic [31:0] data;
  } tsr_word_t;

endpackage

/* src/tsr_recorder.sv */
/*
  Recording controller of one acquisition card: streams samples toward the
  drive or captures triggered sweeps into card memory, then drains them.
  Assumes samples, channel triggers and formula triggers arrive on mclk_i;
  the external trigger pin is asynchronous.
*/
// The implementer's own choices: the address map and the plain strobed port.
// Functional notes
// - Stream mode sends every sample from start, no trigger needed.
// - Unbuffered trigger mode keeps only pre and post data around one trigger.
// - Buffered mode captures into trigger memory, then drains as fast as possible.
// - Buffered low-rate mode also streams half-rate data, sharing output bandwidth.
// - In streaming modes card memory is a FIFO toward the drive.
// - A full streaming FIFO suspends recording while draining continues.
// - Resume only once this and all peer FIFOs are empty.
// - Each suspension interval puts a gap marker into the stream.
// - An early trigger is accepted with a shortened pre-trigger segment.
// - Post-trigger policy is first, every or stop trigger.
// - First policy: trigger starts post; later triggers ignored, no between data.
// - Every policy: retrigger restarts post; captured post becomes between data.
// - Stop policy: trigger starts between; stop-trigger starts post.
// - Stop policy ignores misplaced triggers and stop-triggers.
// - First policy sweep needs pre plus post free; else record trigger only.
// - Retrigger extends only if the extra post fits; else sweep ends as is.
// - Stop policy sweep needs pre, between allowance and post free.
// - Stop policy sweep ends when memory fills before the stop-trigger.
// - Triggers from pin, channels, formulas; stop-triggers from pin, formulas.
// - A stored sweep holds at least ten samples and fits memory; stop-policy sweeps get no ten-sample floor here.
`timescale 1ns/100ps
`default_nettype none
`include "tsr_regs.svh"

module tsr_recorder #(
  parameter int DEPTH = 64,
  parameter int SAMPLE_HZ = 2_000_000
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire tsr_pkg::tsr_bus_t bus_i,
  output logic [31:0] rd_data_o,
  // Sample input
  input wire logic smp_valid_i,
  input wire logic [31:0] smp_data_i,
  // Trigger sources
  input wire logic ext_trig_i,
  input wire logic chan_trig_i,
  input wire logic formula_trig_i,
  input wire logic formula_stop_i,
  // Peer cards
  input wire logic peers_empty_i,
  // Output stream toward the drive
  output logic out_valid_o,
  output tsr_pkg::tsr_word_t out_word_o,
  input wire logic out_ready_i,
  output logic suspended_o
);
  import tsr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [31:0] ALLOW_SMP = 32'(`TSR_BTW_ALLOW_US * (SAMPLE_HZ / 1000) / 1000);
  localparam logic [31:0] MIN_SWEEP = 32'(`TSR_MIN_SWEEP);
  localparam logic [31:0] DEPTH_W = 32'(DEPTH);

  if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two of at least 16");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic rst_meta, rst_n;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic ext_m, ext_s, ext_d;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_m <= 1'b0;
      ext_s <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      ext_m <= ext_trig_i;
      ext_s <= ext_m;
      ext_d <= ext_s;
    end
  end

  logic [31:0] ctrl, pre_len, post_len, allow_len;
  logic [31:0] sweeps, misses, gaps, last_btw, tstamp;
  tsr_state_t state;
  logic run_q, susp, gap_pend, rec_v, lr_v, lr_tgl;
  tsr_word_t rec_w;
  logic [31:0] lr_w;
  logic [31:0] mem [DEPTH];
  logic [AW:0] wp, rp, base;
  logic [31:0] post_left, post_eff_q, btw_cnt;

  wire run = ctrl[`TSR_CTRL_RUN];
  wire tsr_mode_t mode = tsr_mode_t'(ctrl[`TSR_CTRL_MODE_LSB +: 2]);
  wire tsr_policy_t pol = tsr_policy_t'(ctrl[`TSR_CTRL_POL_LSB +: 2]);
  wire [2:0] tsel = ctrl[`TSR_CTRL_TSEL_LSB +: 3];
  wire [1:0] ssel = ctrl[`TSR_CTRL_SSEL_LSB +: 2];
  wire start = run & ~run_q;
  wire ext_rise = ext_s & ~ext_d;

  wire [2:0] src = {formula_trig_i, chan_trig_i, ext_rise} & tsel;
  wire trig = |src;
  wire stop = |({formula_stop_i, ext_rise} & ssel);
  wire streaming = (mode == TSR_MODE_STREAM) || (mode == TSR_MODE_TRIG);

  wire [AW:0] used = wp - rp;
  wire full = used == (AW + 1)'(DEPTH);
  wire [31:0] pre_cnt = 32'(wp - base);
  wire [31:0] free_b = DEPTH_W - 32'(base - rp);
  wire [31:0] free_w = DEPTH_W - 32'(used);
  wire [AW:0] lim = (state == TSR_ST_PRE) ? base : wp;

  logic capture, we, pre_slide;
  always_comb begin
    capture = 1'b0;
    unique case (state)
      TSR_ST_STREAM, TSR_ST_BTW, TSR_ST_POST: capture = 1'b1;
      TSR_ST_PRE: capture = pre_len != 32'h0000_0000;
      TSR_ST_IDLE, TSR_ST_DONE: capture = 1'b0;
    endcase
    we = smp_valid_i & run_q & ~susp & ~full & capture;
    // History is trimmed only once earlier sweeps have drained, so a dropped
    // pre-trigger sample never reaches the stream.
    pre_slide = (state == TSR_ST_PRE) & (rp == base) & ((pre_cnt + 32'(we)) > pre_len);
  end
  wire [AW:0] wp_nx = wp + (AW + 1)'(we);

  // Post length grows when the pre-trigger segment plus post_len is short of a whole sweep.
  wire [31:0] post_eff = (pre_cnt + post_len < MIN_SWEEP) ? MIN_SWEEP - pre_cnt
                                                          : post_len;
  wire fits_first = pre_cnt + post_eff <= free_b;
  wire fits_stop = pre_cnt + ALLOW_SMP + post_len <= free_b;
  wire [31:0] post_done = post_eff_q - post_left;
  wire fits_extra = post_done <= free_w;

  logic take_gap, take_rec, take_lr, take_mem, out_load;
  always_comb begin
    out_load = ~out_valid_o | out_ready_i;
    take_gap = out_load & gap_pend;
    take_rec = out_load & ~gap_pend & rec_v;
    take_lr = out_load & ~gap_pend & ~rec_v & lr_v;
    take_mem = out_load & ~gap_pend & ~rec_v & ~lr_v & (rp != lim);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `TSR_RST_CTRL;
      pre_len <= `TSR_RST_PRE;
      post_len <= `TSR_RST_POST;
      allow_len <= 32'h0000_0000;
    end else if (bus_i.wr) begin
      if (hit(bus_i.addr, `TSR_OFF_CTRL)) ctrl <= bus_i.wdata;
      if (hit(bus_i.addr, `TSR_OFF_PRE)) pre_len <= bus_i.wdata;
      if (hit(bus_i.addr, `TSR_OFF_POST)) post_len <= bus_i.wdata;
    end else begin
      allow_len <= ALLOW_SMP;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        `TSR_OFF_CTRL: rd_data_o <= ctrl;
        `TSR_OFF_PRE: rd_data_o <= pre_len;
        `TSR_OFF_POST: rd_data_o <= post_len;
        `TSR_OFF_ALLOW: rd_data_o <= allow_len;
        `TSR_OFF_STATUS: rd_data_o <= {8'h00, 3'(state), susp, full, 3'h0, 16'(used)};
        `TSR_OFF_SWEEPS: rd_data_o <= sweeps;
        `TSR_OFF_MISSES: rd_data_o <= misses;
        `TSR_OFF_GAPS: rd_data_o <= gaps;
        `TSR_OFF_BETWEEN: rd_data_o <= last_btw;
        default: rd_data_o <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tstamp <= 32'h0000_0000;
      run_q <= 1'b0;
    end else begin
      tstamp <= tstamp + 32'h0000_0001;
      run_q <= run;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (we) begin
      mem[wp[AW-1:0]] <= smp_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
    end else if (start) begin
      wp <= '0;
    end else begin
      wp <= wp_nx;
    end
  end

  // Sweep engine: segment states, admission checks and sweep bookkeeping.
  logic end_sw;
  always_comb begin
    end_sw = 1'b0;
    if (state == TSR_ST_POST && we && post_left == 32'h0000_0001) begin
      end_sw = 1'b1;
    end
    if (state == TSR_ST_BTW && full && !streaming) begin
      end_sw = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= TSR_ST_IDLE;
      base <= '0;
      post_left <= 32'h0000_0000;
      post_eff_q <= 32'h0000_0000;
      btw_cnt <= 32'h0000_0000;
      last_btw <= 32'h0000_0000;
      sweeps <= 32'h0000_0000;
      misses <= 32'h0000_0000;
      rec_v <= 1'b0;
      rec_w <= '0;
    end else begin
      if (take_rec) begin
        rec_v <= 1'b0;
      end
      if (!run) begin
        state <= TSR_ST_IDLE;
      end else if (start) begin
        base <= '0;
        sweeps <= 32'h0000_0000;
        misses <= 32'h0000_0000;
        state <= (mode == TSR_MODE_STREAM) ? TSR_ST_STREAM : TSR_ST_PRE;
      end else begin
        unique case (state)
          TSR_ST_IDLE, TSR_ST_STREAM, TSR_ST_DONE: begin
          end
          TSR_ST_PRE: begin
            if (pre_slide) begin
              base <= base + (AW + 1)'(1);
            end
            if (trig) begin
              rec_v <= 1'b1;
              rec_w.src <= src;
              rec_w.data <= tstamp;
              if (pol == TSR_POL_STOP && (fits_stop || streaming)) begin
                state <= TSR_ST_BTW;
                btw_cnt <= 32'h0000_0000;
                rec_w.kind <= TSR_KIND_TRIG;
                base <= wp_nx;
              end else if (pol != TSR_POL_STOP && (fits_first || streaming)) begin
                // The pre-trigger segment is whatever has been gathered so far.
                state <= (post_eff == 32'h0000_0000) ? TSR_ST_PRE : TSR_ST_POST;
                post_left <= post_eff;
                post_eff_q <= post_eff;
                btw_cnt <= 32'h0000_0000;
                rec_w.kind <= TSR_KIND_TRIG;
                base <= wp_nx;
                sweeps <= sweeps + 32'h0000_0001;
              end else begin
                rec_w.kind <= TSR_KIND_MISS;
                misses <= misses + 32'h0000_0001;
              end
            end
          end
          TSR_ST_BTW: begin
            if (we) begin
              btw_cnt <= btw_cnt + 32'h0000_0001;
            end
            if (end_sw) begin
              state <= TSR_ST_PRE;
              base <= wp_nx;
              last_btw <= btw_cnt;
              sweeps <= sweeps + 32'h0000_0001;
            end else if (stop) begin
              // Triggers are not looked at here at all.
              state <= (post_len == 32'h0000_0000) ? TSR_ST_PRE : TSR_ST_POST;
              base <= wp_nx;
              post_left <= post_len;
              post_eff_q <= post_len;
              last_btw <= btw_cnt;
              sweeps <= sweeps + 32'h0000_0001;
            end
          end
          TSR_ST_POST: begin
            base <= wp_nx;
            if (trig && pol == TSR_POL_EVERY && (fits_extra || streaming)) begin
              btw_cnt <= btw_cnt + post_done;
              post_left <= post_eff_q;
            end else if (end_sw) begin
              state <= (mode == TSR_MODE_TRIG) ? TSR_ST_DONE : TSR_ST_PRE;
              last_btw <= btw_cnt;
            end else if (we) begin
              post_left <= post_left - 32'h0000_0001;
            end
          end
        endcase
      end
    end
  end

  // Suspension applies only while memory acts as the streaming FIFO.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      susp <= 1'b0;
      gap_pend <= 1'b0;
      gaps <= 32'h0000_0000;
    end else begin
      if (start) begin
        susp <= 1'b0;
        gaps <= 32'h0000_0000;
      end else if (streaming && full && run_q) begin
        susp <= 1'b1;
      end else if (susp && used == '0 && peers_empty_i) begin
        susp <= 1'b0;
        gaps <= gaps + 32'h0000_0001;
      end
      if (susp && used == '0 && peers_empty_i && !start) begin
        gap_pend <= 1'b1;
      end else if (take_gap) begin
        gap_pend <= 1'b0;
      end
    end
  end

  // The low-rate path holds one half-rate sample; a newer one is lost while it waits.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lr_tgl <= 1'b0;
      lr_v <= 1'b0;
      lr_w <= 32'h0000_0000;
    end else begin
      if (smp_valid_i && run_q && mode == TSR_MODE_BUF_LOW) begin
        lr_tgl <= ~lr_tgl;
      end
      if (smp_valid_i && run_q && mode == TSR_MODE_BUF_LOW && lr_tgl && !lr_v) begin
        lr_v <= 1'b1;
        lr_w <= smp_data_i;
      end else if (take_lr) begin
        lr_v <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rp <= '0;
      out_valid_o <= 1'b0;
      out_word_o <= '0;
    end else begin
      if (start) begin
        rp <= '0;
      end else if (take_mem || pre_slide) begin
        rp <= rp + (AW + 1)'(1);
      end
      if (out_load) begin
        out_valid_o <= take_gap | take_rec | take_lr | take_mem;
        if (take_gap) begin
          out_word_o <= '{kind: TSR_KIND_GAP, src: 3'h0, data: gaps};
        end else if (take_rec) begin
          out_word_o <= rec_w;
        end else if (take_lr) begin
          out_word_o <= '{kind: TSR_KIND_SAMPLE, src: 3'h0, data: lr_w};
        end else begin
          out_word_o <= '{kind: TSR_KIND_SAMPLE, src: 3'h0, data: mem[rp[AW-1:0]]};
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      suspended_o <= 1'b0;
    end else begin
      suspended_o <= susp;
    end
  end

endmodule
`default_nettype wire

/* dv/tsr_assertions.sv */
/*
  Port checker of the sweep recorder: read timing, stream hold, suspension.
  Assumes a bind onto tsr_recorder and a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module tsr_assertions (
  // Watched ports
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire tsr_pkg::tsr_bus_t bus_i,
  input wire logic [31:0] rd_data_o,
  input wire logic peers_empty_i,
  input wire logic out_valid_o,
  input wire tsr_pkg::tsr_word_t out_word_o,
  input wire logic out_ready_i,
  input wire logic suspended_o
);
  import tsr_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic stall = out_valid_o && !out_ready_i;
  wire logic gap_w = out_valid_o && out_word_o.kind == TSR_KIND_GAP;
  a_read_window: assert property (rd_data_o != 0 |-> $past(bus_i.rd))
    else $error("read data outside its cycle");
  a_valid_hold: assert property (stall |=> out_valid_o)
    else $error("stalled word withdrawn");
  a_word_hold: assert property (stall |=> $stable(out_word_o))
    else $error("stalled word changed");
  a_susp_wait: assert property (suspended_o && !peers_empty_i |=> suspended_o)
    else $error("resumed while a peer still holds data");
  a_resume_peers: assert property ($fell(suspended_o) |-> $past(peers_empty_i, 2))
    else $error("resume without empty peers");
  a_gap_marker: assert property ($fell(suspended_o) |-> ##[0:40] gap_w)
    else $error("no gap marker after resume");
  a_gap_after_resume: assert property ($rose(gap_w) |-> !suspended_o)
    else $error("gap marker while still suspended");
  a_trig_src: assert property (out_valid_o && out_word_o.kind == TSR_KIND_TRIG
    |-> out_word_o.src != 3'h0)
    else $error("trigger record without source");
  a_susp_drain: assert property ($rose(suspended_o) |-> ##[0:2] out_valid_o)
    else $error("suspended without draining");
  c_suspend: cover property ($rose(suspended_o));
  c_gap: cover property (gap_w && out_ready_i);
  c_trig: cover property (out_valid_o && out_word_o.kind == TSR_KIND_TRIG);
endmodule
bind tsr_recorder tsr_assertions u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
  .peers_empty_i(peers_empty_i), .out_valid_o(out_valid_o),
  .out_word_o(out_word_o), .out_ready_i(out_ready_i), .suspended_o(suspended_o)
);
`default_nettype wire

/* dv/tsr_drive_model.sv */
/*
  Drive side of the stream: accepts words at full or quarter rate and tallies
  the sample and gap words. Assumes the recorder's clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tsr_drive_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Pace from the bench
  input wire logic slow_i,
  // Stream
  input wire logic valid_i,
  input wire tsr_pkg::tsr_word_t word_i,
  output logic ready_o,
  // Tallies
  output logic [31:0] n_smp_o,
  output logic [31:0] n_gap_o,
  output logic [31:0] last_o
);
  import tsr_pkg::*;
  logic [1:0] ph;
  // A slow drive takes one word in four, which is what fills the FIFO.
  assign ready_o = !slow_i || ph == 2'h0;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph <= '0;
      n_smp_o <= '0;
      n_gap_o <= '0;
      last_o <= '0;
    end else begin
      ph <= ph + 2'h1;
      if (valid_i && ready_o && word_i.kind == TSR_KIND_SAMPLE) begin
        n_smp_o <= n_smp_o + 32'h0000_0001;
        last_o <= word_i.data;
      end
      if (valid_i && ready_o && word_i.kind == TSR_KIND_GAP) begin
        n_gap_o <= n_gap_o + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/triggered_sweep_recorder_tb.sv */
/*
  Bench of the recorder: a table of recording cases, then registers and
  stream suspension. Assumes the drive model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tsr_regs.svh"
module triggered_sweep_recorder_tb;
  import tsr_pkg::*;
  typedef struct {
    logic [31:0] ctrl, pre, post;
    int tr, tr2, sp;
    logic [31:0] smp, sw, ms, last;
  } tsr_row_t;
  localparam logic [31:0] SKIP = 32'hFFFF_FFFF;
  logic mclk_i = 0, rst_b_i = 0, feed = 0, slow = 0, peers = 1;
  logic smp_valid_i = 0, chan_trig_i = 0, formula_stop_i = 0;
  logic [31:0] smp_data_i = '0, rd_data_o, d, n_smp, n_gap, last;
  tsr_bus_t bus_i = '0;
  tsr_word_t out_word_o;
  logic out_valid_o, out_ready_i, suspended_o;
  int idx = 0, err_total = 0, checked = 0;
  tsr_row_t cur, rows [9];
  always #4 mclk_i = !mclk_i;
  tsr_recorder #(.SAMPLE_HZ(4000)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .bus_i(bus_i), .rd_data_o(rd_data_o), .smp_valid_i(smp_valid_i),
    .smp_data_i(smp_data_i), .ext_trig_i(1'b0), .chan_trig_i(chan_trig_i),
    .formula_trig_i(1'b0), .formula_stop_i(formula_stop_i),
    .peers_empty_i(peers), .out_valid_o(out_valid_o), .out_word_o(out_word_o),
    .out_ready_i(out_ready_i), .suspended_o(suspended_o));
  tsr_drive_model drv (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .valid_i(out_valid_o), .word_i(out_word_o), .ready_o(out_ready_i),
    .n_smp_o(n_smp), .n_gap_o(n_gap), .last_o(last));
  // Sample words carry their index so the last stored one names the sweep end.
  always @(posedge mclk_i) begin
    smp_valid_i <= feed;
    smp_data_i <= 32'h0000_0100 + idx;
    chan_trig_i <= feed && (idx == cur.tr || idx == cur.tr2);
    formula_stop_i <= feed && idx == cur.sp;
    if (feed) idx <= idx + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i) bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i) bus_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i) bus_i <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i) bus_i <= '0;
    #1 d = rd_data_o;
  endtask
  task automatic reset_dut();
    @(posedge mclk_i) rst_b_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400us;
    err_total++;
    close_out();
  end
  initial begin
    rows[0] = '{32'h0000_03E1, 4, 8, -1, -1, -1, 60, 0, 0, 32'h0000_013B};
    rows[1] = '{32'h0000_03E3, 4, 8, 10, -1, -1, 12, SKIP, 0, 32'h0000_0112};
    rows[2] = '{32'h0000_03E5, 4, 8, 10, 14, -1, 12, 1, 0, 32'h0000_0112};
    rows[3] = '{32'h0000_03ED, 4, 8, 10, 14, -1, 16, 1, 0, 32'h0000_0116};
    rows[4] = '{32'h0000_03F5, 4, 8, 10, 13, 16, 18, 1, 0, 32'h0000_0118};
    rows[5] = '{32'h0000_03E5, 8, 8, 2, -1, -1, 11, 1, 0, 32'h0000_010A};
    rows[6] = '{32'h0000_03E5, 2, 3, 10, -1, -1, 10, 1, 0, 32'h0000_0112};
    rows[7] = '{32'h0000_03E5, 30, 40, 35, -1, -1, 0, 0, 1, SKIP};
    rows[8] = '{32'h0000_03E7, 4, 8, 10, -1, -1, 42, 1, 0, SKIP};
    foreach (rows[i]) begin
      cur = rows[i];
      reset_dut();
      wr(`TSR_OFF_PRE, cur.pre);
      wr(`TSR_OFF_POST, cur.post);
      wr(`TSR_OFF_CTRL, cur.ctrl);
      @(posedge mclk_i) idx <= 0;
      feed <= 1'b1;
      repeat (60) @(posedge mclk_i);
      feed <= 1'b0;
      repeat (300) @(posedge mclk_i);
      chk("samples", n_smp, cur.smp);
      if (cur.last !== SKIP) chk("last sample", last, cur.last);
      rd(`TSR_OFF_SWEEPS);
      if (cur.sw !== SKIP) chk("sweeps", d, cur.sw);
      rd(`TSR_OFF_MISSES);
      chk("misses", d, cur.ms);
    end
    cur = '{0, 0, 0, -1, -1, -1, 0, 0, 0, 0};
    reset_dut();
    rd(`TSR_OFF_CTRL);
    chk("ctrl reset", d, `TSR_RST_CTRL);
    rd(`TSR_OFF_PRE);
    chk("pre reset", d, `TSR_RST_PRE);
    rd(`TSR_OFF_POST);
    chk("post reset", d, `TSR_RST_POST);
    rd(8'h24);
    chk("unmapped", d, 32'h0000_0000);
    wr(`TSR_OFF_ALLOW, 32'h0000_0000);
    rd(`TSR_OFF_ALLOW);
    chk("allowance", d, 32'h0000_000A);
    slow <= 1'b1;
    peers <= 1'b0;
    wr(`TSR_OFF_CTRL, 32'h0000_03E1);
    feed <= 1'b1;
    repeat (150) @(posedge mclk_i);
    #1 chk("suspend", suspended_o, 1'b1);
    feed <= 1'b0;
    slow <= 1'b0;
    repeat (150) @(posedge mclk_i);
    #1 chk("held", suspended_o, 1'b1);
    peers <= 1'b1;
    repeat (50) @(posedge mclk_i);
    #1 chk("resumed", suspended_o, 1'b0);
    chk("gap words", n_gap, 32'h0000_0001);
    rd(`TSR_OFF_GAPS);
    chk("gap count", d, 32'h0000_0001);
    close_out();
  end
endmodule
`default_nettype wire
